// ### src/abx_pkg.sv
`default_nettype none
package abx_pkg;
	// Instruction word layout (14-bit)
	localparam int INSN_W      = 14;
	localparam int DATA_W      = 8;
	localparam int FADDR_W     = 7;
	localparam int BITSEL_W    = 3;
	localparam int PC_W        = 13;
	localparam int DEST_BIT    = 7;
	localparam int BSEL_LSB    = 7;
	localparam int NIBBLE_W    = 4;
	// Opcode fields
	localparam logic [5:0] OP_ADD_FILE  = 6'h07;
	localparam logic [5:0] OP_AND_FILE  = 6'h05;
	localparam logic [3:0] OP_BIT_CLR   = 4'h4;
	localparam logic [3:0] OP_BIT_SET   = 4'h5;
	localparam logic [3:0] OP_BIT_TSC   = 4'h6;
	localparam logic [4:0] OP_ADD_LIT   = 5'h1f;
	localparam logic [5:0] OP_AND_LIT   = 6'h39;
	// Status bit positions in the flag output
	localparam int FLAG_C  = 0;
	localparam int FLAG_DC = 1;
	localparam int FLAG_Z  = 2;
	// Reset values
	localparam logic [7:0]  ACC_RST  = 8'h00;
	localparam logic [2:0]  FLAG_RST = 3'h0;
	localparam logic [12:0] PC_RST   = 13'h0000;
	// Address of the I/O port register read from pins
	localparam logic [6:0]  PORT_ADDR = 7'h05;
	typedef enum logic [2:0] {
		ABX_NOP, ABX_ADD_LIT, ABX_ADD_FILE, ABX_AND_LIT, ABX_AND_FILE,
		ABX_BIT_CLR, ABX_BIT_SET, ABX_BIT_TSC
	} abx_op_t;
endpackage : abx_pkg
`default_nettype wire

// ### src/abx_decode.sv
`default_nettype none
module abx_decode
	import abx_pkg::*;
(
	// Instruction word
	input  wire logic [abx_pkg::INSN_W-1:0] insn_in,
	// Decoded operation
	output abx_pkg::abx_op_t                op_out
);
	always_comb begin
		op_out = ABX_NOP;
		if (insn_in[13:8] == OP_ADD_FILE) begin
			op_out = ABX_ADD_FILE;
		end else if (insn_in[13:8] == OP_AND_FILE) begin
			op_out = ABX_AND_FILE;
		end else if (insn_in[13:10] == OP_BIT_CLR) begin
			op_out = ABX_BIT_CLR;
		end else if (insn_in[13:10] == OP_BIT_SET) begin
			op_out = ABX_BIT_SET;
		end else if (insn_in[13:10] == OP_BIT_TSC) begin
			op_out = ABX_BIT_TSC;
		end else if (insn_in[13:9] == OP_ADD_LIT) begin
			op_out = ABX_ADD_LIT;
		end else if (insn_in[13:8] == OP_AND_LIT) begin
			op_out = ABX_AND_LIT;
		end
	end
endmodule : abx_decode
`default_nettype wire

// ### src/abx_core.sv
// The address map and the strobed register port were decided locally.
`default_nettype none
module abx_core
	import abx_pkg::*;
(
	// Clock and reset
	input  wire logic                        core_clk_in,
	input  wire logic                        sys_rst_in,
	// Program memory
	input  wire logic [abx_pkg::INSN_W-1:0]  insn_in,
	output logic      [abx_pkg::PC_W-1:0]    pc_out,
	// Data register file, read combinationally at file_addr_out
	output logic      [abx_pkg::FADDR_W-1:0] file_addr_out,
	input  wire logic [abx_pkg::DATA_W-1:0]  file_rdata_in,
	output logic                             file_we_out,
	output logic      [abx_pkg::FADDR_W-1:0] file_waddr_out,
	output logic      [abx_pkg::DATA_W-1:0]  file_wdata_out,
	// Port pins
	input  wire logic [abx_pkg::DATA_W-1:0]  port_pins_in,
	// Core state
	output logic      [abx_pkg::DATA_W-1:0]  acc_out,
	output logic      [2:0]                  flags_out,
	output logic                             skip_out
);
	import abx_pkg::*;

	// ****************************************
	// Decode
	// ****************************************
	abx_op_t                op;
	logic [FADDR_W-1:0]     faddr;
	logic [BITSEL_W-1:0]    bsel;
	logic                   dest_file;
	logic [DATA_W-1:0]      lit;
	logic [DATA_W-1:0]      fsrc;

	abx_decode u_dec (
		.insn_in (insn_in),
		.op_out  (op)
	);

	assign faddr     = insn_in[FADDR_W-1:0];
	assign bsel      = insn_in[BSEL_LSB +: BITSEL_W];
	assign dest_file = insn_in[DEST_BIT];
	assign lit       = insn_in[DATA_W-1:0];
	assign file_addr_out = faddr;

	// Pin levels replace latch contents
	// port from pins
	assign fsrc = (faddr == PORT_ADDR) ? port_pins_in : file_rdata_in;

	function automatic logic [DATA_W:0] add8(input logic [DATA_W-1:0] a,
						 input logic [DATA_W-1:0] b);
		add8 = {1'b0, a} + {1'b0, b};
	endfunction : add8

	function automatic logic nib_carry(input logic [DATA_W-1:0] a,
					   input logic [DATA_W-1:0] b);
		logic [NIBBLE_W:0] s;
		s = {1'b0, a[NIBBLE_W-1:0]} + {1'b0, b[NIBBLE_W-1:0]};
		nib_carry = s[NIBBLE_W];
	endfunction : nib_carry

	// ****************************************
	// Execute
	// ****************************************
	logic [DATA_W-1:0]  acc;
	logic [2:0]         flags;
	logic               skip;
	logic [PC_W-1:0]    pc;
	logic               we;
	logic [FADDR_W-1:0] waddr;
	logic [DATA_W-1:0]  wdata;
	logic [DATA_W-1:0]  next_acc;
	logic [2:0]         next_flags;
	logic               next_skip;
	logic [PC_W-1:0]    next_pc;
	logic               next_we;
	logic [FADDR_W-1:0] next_waddr;
	logic [DATA_W-1:0]  next_wdata;

	always_comb begin
		logic [DATA_W:0]   sum;
		logic [DATA_W-1:0] res;
		logic [DATA_W-1:0] mask;
		sum  = '0;
		res  = '0;
		mask = DATA_W'(1) << bsel;
		next_acc   = acc;
		next_flags = flags;
		next_skip  = 1'b0;
		next_pc    = PC_W'(pc + PC_W'(1));
		next_we    = 1'b0;
		next_waddr = faddr;
		next_wdata = wdata;
		// Discarded slot: instruction word is ignored
		// second cycle nop
		if (!skip) begin
			unique case (op)
				ABX_ADD_LIT: begin
					sum = add8(acc, lit);
					next_acc = sum[DATA_W-1:0];
					next_flags[FLAG_C]  = sum[DATA_W];
					next_flags[FLAG_DC] = nib_carry(acc, lit);
					next_flags[FLAG_Z]  = (sum[DATA_W-1:0] == '0);
				end
				ABX_ADD_FILE: begin
					sum = add8(acc, fsrc);
					res = sum[DATA_W-1:0];
					next_flags[FLAG_C]  = sum[DATA_W];
					next_flags[FLAG_DC] = nib_carry(acc, fsrc);
					next_flags[FLAG_Z]  = (res == '0);
					if (dest_file) begin
						next_we    = 1'b1;
						next_wdata = res;
					end else begin
						next_acc = res;
					end
				end
				ABX_AND_LIT: begin
					res = acc & lit;
					next_acc = res;
					next_flags[FLAG_Z] = (res == '0);
				end
				ABX_AND_FILE: begin
					res = acc & fsrc;
					next_flags[FLAG_Z] = (res == '0);
					if (dest_file) begin
						next_we    = 1'b1;
						next_wdata = res;
					end else begin
						next_acc = res;
					end
				end
				ABX_BIT_CLR: begin
					next_we    = 1'b1;
					next_wdata = fsrc & ~mask;
				end
				ABX_BIT_SET: begin
					next_we    = 1'b1;
					next_wdata = fsrc | mask;
				end
				ABX_BIT_TSC: begin
					next_skip = ((fsrc & mask) == '0);
				end
				ABX_NOP: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			acc   <= ACC_RST;
			flags <= FLAG_RST;
			skip  <= 1'b0;
			pc    <= PC_RST;
			we    <= 1'b0;
			waddr <= '0;
			wdata <= '0;
		end else begin
			acc   <= next_acc;
			flags <= next_flags;
			skip  <= next_skip;
			pc    <= next_pc;
			we    <= next_we;
			waddr <= next_waddr;
			wdata <= next_wdata;
		end
	end

	assign acc_out        = acc;
	assign flags_out      = flags;
	assign skip_out       = skip;
	assign pc_out         = pc;
	assign file_we_out    = we;
	assign file_waddr_out = waddr;
	assign file_wdata_out = wdata;
endmodule : abx_core
`default_nettype wire

// ### sim/abx_file_model.sv
`default_nettype none
module abx_file_model (
	// Read port
	input  wire logic       clk_in,
	input  wire logic [6:0] addr_in,
	output logic      [7:0] rdata_out,
	// Write port
	input  wire logic       we_in,
	input  wire logic [6:0] waddr_in,
	input  wire logic [7:0] wdata_in
);
	logic [7:0] mem [128] = '{default: 8'h00};
	// Write-through: the next instruction reads what the last one wrote
	assign rdata_out = (we_in && waddr_in == addr_in) ? wdata_in : mem[addr_in];
	always @(posedge clk_in)
		if (we_in)
			mem[waddr_in] <= wdata_in;
endmodule : abx_file_model
`default_nettype wire

// ### sim/abx_core_properties.sv
`default_nettype none
module abx_core_chk
	import abx_pkg::*;
(
	input wire logic        core_clk_in,
	input wire logic        sys_rst_in,
	input wire logic [13:0] insn_in,
	input wire logic [7:0]  file_rdata_in,
	input wire logic [7:0]  port_pins_in,
	input wire logic        file_we_out,
	input wire logic [6:0]  file_waddr_out,
	input wire logic [7:0]  file_wdata_out,
	input wire logic [7:0]  acc_out,
	input wire logic [2:0]  flags_out,
	input wire logic        skip_out,
	input wire logic [12:0] pc_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	wire logic [7:0] one = 8'h01 << insn_in[9:7];
	wire logic       pa  = insn_in[6:0] == PORT_ADDR;
	wire logic       al  = !skip_out && insn_in[13:9] == OP_ADD_LIT;
	wire logic       nl  = !skip_out && insn_in[13:8] == OP_AND_LIT;
	wire logic       af  = !skip_out && !pa && insn_in[13:8] == OP_ADD_FILE;
	wire logic       nf  = !skip_out && !pa && insn_in[13:8] == OP_AND_FILE;
	wire logic [3:0] bo  = skip_out ? 4'h0 : insn_in[13:10];
	sequence skip_seq;
		skip_out ##1 !skip_out;
	endsequence
	add_lit_a: assert property (
		al |=> acc_out == $past(acc_out + insn_in[7:0])) else $error("add literal");
	add_carry_a: assert property (
		al |=> flags_out[FLAG_C] == $past({1'b0, acc_out} + insn_in[7:0]) >> 8) else $error("carry");
	and_lit_a: assert property (
		nl |=> acc_out == $past(acc_out & insn_in[7:0]) && $stable(flags_out[1:0])) else $error("and lit");
	zero_flag_a: assert property (
		al || nl |=> flags_out[FLAG_Z] == (acc_out == 8'h00)) else $error("zero flag");
	add_file_a: assert property (
		af && insn_in[7] |=> file_we_out && file_waddr_out == $past(insn_in[6:0])
		&& file_wdata_out == $past(acc_out + file_rdata_in)) else $error("add file");
	and_file_a: assert property (
		nf && !insn_in[7] |=> acc_out == $past(acc_out & file_rdata_in) && !file_we_out) else $error("and file");
	bit_clr_a: assert property (
		bo == OP_BIT_CLR && !pa |=> file_wdata_out == $past(file_rdata_in & ~one) && $stable(flags_out))
		else $error("bit clear");
	port_src_a: assert property (
		bo == OP_BIT_SET && pa |=> file_wdata_out == $past(port_pins_in | one)) else $error("pin source");
	skip_clr_a: assert property (
		bo == OP_BIT_TSC && !pa && (file_rdata_in & one) == 8'h00 |=> skip_seq) else $error("skip");
	skip_nop_a: assert property (
		skip_out |=> !file_we_out && $stable(acc_out)) else $error("skipped cycle acted");
	bit_set_a: assert property (
		bo == OP_BIT_SET && !pa |=> file_we_out && file_wdata_out == $past(file_rdata_in | one)
		&& $stable(flags_out)) else $error("bit set");
	pc_step_a: assert property (
		!sys_rst_in |=> pc_out == 13'($past(pc_out) + 13'h0001)) else $error("pc step");
endmodule : abx_core_chk
bind abx_core abx_core_chk u_chk (.core_clk_in, .sys_rst_in, .insn_in, .file_rdata_in, .port_pins_in,
	.file_we_out, .file_waddr_out, .file_wdata_out, .acc_out, .flags_out, .skip_out, .pc_out);
`default_nettype wire

// ### sim/abx_core_bench.sv
`default_nettype none
module abx_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import abx_pkg::*;
	logic        core_clk_in = 0, sys_rst_in = 1, file_we_out, skip_out, sk = 0, hv = 0;
	logic [13:0] insn_in = '0;
	logic [12:0] pc_out;
	logic [6:0]  file_addr_out, file_waddr_out;
	logic [7:0]  file_rdata_in, file_wdata_out, acc_out, port_pins_in = '0, a = 0;
	logic [7:0]  m [128] = '{default: 8'h00};
	logic [2:0]  flags_out, fl = 0;
	logic [11:0] q [$], h;
	int          seed = 42, error_cnt = 0, checks = 0;
	always #12.5 core_clk_in = ~core_clk_in;
	abx_core u_dut (.core_clk_in, .sys_rst_in, .insn_in, .pc_out, .file_addr_out, .file_rdata_in,
		.file_we_out, .file_waddr_out, .file_wdata_out, .port_pins_in, .acc_out, .flags_out, .skip_out);
	abx_file_model u_file (.clk_in(core_clk_in), .addr_in(file_addr_out), .rdata_out(file_rdata_in),
		.we_in(file_we_out), .waddr_in(file_waddr_out), .wdata_in(file_wdata_out));
	// ****************
	// Scoreboard
	// ****************
	always @(negedge core_clk_in) begin
		if (hv) begin
			checks++;
			if ({skip_out, flags_out, acc_out} !== h) begin
				error_cnt++;
				$display("mismatch at %0t: got %h expected %h", $time, {skip_out, flags_out, acc_out}, h);
			end
		end
		hv = q.size() > 0;
		if (hv)
			h = q.pop_front();
	end
	// Ops 0..6: add lit, and lit, add file, and file, clear, set, test
	task automatic ex(input int o);
		logic [7:0] k, p, s, v, r;
		logic [8:0] t;
		k = 8'($random(seed));
		p = 8'($random(seed));
		s = {4'h0, k[5:3]} == PORT_ADDR ? p : m[k[5:3]];
		v = o < 2 ? k : s;
		t = {1'b0, a} + v;
		r = o > 4 ? s | 8'h01 << k[2:0] : o > 3 ? s & ~(8'h01 << k[2:0]) : o[0] ? a & v : t[7:0];
		@(posedge core_clk_in);
		insn_in <= o == 0 ? {OP_ADD_LIT, 1'b0, k} : o == 1 ? {OP_AND_LIT, k}
			: o == 2 ? {OP_ADD_FILE, k[7], 4'h0, k[5:3]} : o == 3 ? {OP_AND_FILE, k[7], 4'h0, k[5:3]}
			: {o == 4 ? OP_BIT_CLR : o == 5 ? OP_BIT_SET : OP_BIT_TSC, k[2:0], 4'h0, k[5:3]};
		port_pins_in <= p;
		if (!sk) begin
			if (o < 4)
				fl[FLAG_Z] = r == 8'h00;
			if (o == 0 || o == 2)
				fl[1:0] = {a[3:0] + v[3:0] > 15, t[8]};
			if (o < 2 || (o < 4 && !k[7]))
				a = r;
			else if (o < 6)
				m[k[5:3]] = r;
			sk = o == 6 && !s[k[2:0]];
		end else
			sk = 0;
		q.push_back({sk, fl, a});
	endtask : ex
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (12) @(posedge core_clk_in);
		sys_rst_in <= 0;
		for (int i = 0; i < 600; i++)
			ex($unsigned($random(seed)) % 7);
		repeat (3) @(posedge core_clk_in);
		$display("test random mix done");
		tally_and_finish();
	end
endmodule : abx_core_bench
`default_nettype wire
